// File: pphp_pkg.sv
// Package for the parallel host port: widths, states and timing counts.
// Assumes a single 25 MHz core clock domain.
package pphp_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Cycles in the wait state from access detection to the core request (register access latency)
  localparam int ACCESS_LAT = 2;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  // Clock supervision window in core cycles without a latch-input falling edge
  localparam int SUPV_TIMEOUT = 256;
  typedef enum logic [3:0] {
    PPHP_IDLE = 4'b0001,
    PPHP_WAIT = 4'b0010,
    PPHP_DONE = 4'b0100,
    PPHP_HOLD = 4'b1000
  } pphp_state_e;
endpackage

// File: pphp_host_port.sv
// Parallel host port: strap-selected strobe style and bus muxing, register
// access handshake toward the core, open-drain interrupt and ready.
// Assumes all pins are synchronous to clk; core answers reads in the request cycle.
//
// Contract
// - Strap low: separate read/write strobes, else strobe+direction
// - Strap low: multiplexed bus, else separate buses
// - Selected only while both selects low
// - Dedicated address lines used only demultiplexed
// - Shared lines carry address then data
// - Muxed address captured at latch-strobe falling edge
// - Latch input clocks internal clock supervision
// - Separate style: read strobe low means read
// - Separate style: write strobe low means write; the code takes both strobes low as a read
// - Direction style: data strobe times every access
// - Direction input high read, low write
// - Interrupt pulled low to request service
// - Ready only after read data valid
// - Ready once write accepted
// - Power-on reset forces all state to defaults
`timescale 1ns/1ns
module pphp_host_port
#(
  parameter int SUPV_LIMIT = pphp_pkg::SUPV_TIMEOUT
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic power_on_reset_n,
  input wire logic host_style_strap,
  input wire logic bus_mux_strap,
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic [pphp_pkg::ADDR_W-1:0] dedicated_address_lines,
  input wire logic [pphp_pkg::DATA_W-1:0] sharedIn,
  output logic [pphp_pkg::DATA_W-1:0] sharedOut,
  output logic sharedOe,
  input wire logic addrLatch,
  input wire logic read_or_data_strobe_n,
  input wire logic writeOrDir,
  output logic intOut,
  output logic intOe,
  output logic rdyOut,
  output logic rdyOe,
  input wire logic coreIrq,
  output logic coreReq,
  output logic coreWrite,
  output logic [pphp_pkg::ADDR_W-1:0] coreAddr,
  output logic [pphp_pkg::DATA_W-1:0] coreWdata,
  input wire logic [pphp_pkg::DATA_W-1:0] coreRdata,
  output logic clockFail
);
  import pphp_pkg::*;

  localparam logic [7:0] LAT_MAX = 8'(ACCESS_LAT - 1);
  localparam int SW = $clog2(SUPV_LIMIT + 1);

  pphp_state_e state_q, state_d;
  logic [ADDR_W-1:0] muxAddr_q;
  logic [DATA_W-1:0] rdData_q;
  logic [7:0] lat_q;
  logic latchPrev_q;
  logic [SW-1:0] supv_q;
  logic clockFail_q;
  logic accRead_q;

  wire resetAll = !rst_n || !power_on_reset_n;
  wire selected = !select_a_n && !select_b_n;
  wire dirStyle = host_style_strap;
  wire demuxed = bus_mux_strap;
  wire sepRead = !dirStyle && !read_or_data_strobe_n;
  wire sepWrite = !dirStyle && !writeOrDir;
  wire dsActive = dirStyle && !read_or_data_strobe_n;
  wire dirRead = dsActive && writeOrDir;
  wire dirWrite = dsActive && !writeOrDir;
  wire isRead = selected && (sepRead || dirRead);
  wire isWrite = selected && (sepWrite || dirWrite) && !isRead;
  wire strobeOn = isRead || isWrite;
  wire latchFall = latchPrev_q && !addrLatch;
  // Dedicated lines ignored when multiplexed
  wire [ADDR_W-1:0] accAddr = demuxed ? dedicated_address_lines : muxAddr_q;
  wire latDone = lat_q >= LAT_MAX;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PPHP_IDLE:
        if (strobeOn)
        begin
          state_d = PPHP_WAIT;
        end
      PPHP_WAIT:
        if (!strobeOn)
        begin
          state_d = PPHP_IDLE;
        end
        else if (latDone)
        begin
          state_d = PPHP_DONE;
        end
      PPHP_DONE:
        state_d = PPHP_HOLD;
      PPHP_HOLD:
        if (!strobeOn)
        begin
          state_d = PPHP_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (resetAll)
    begin
      state_q <= PPHP_IDLE;
      lat_q <= 8'h00;
      accRead_q <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      lat_q <= (state_q == PPHP_WAIT) ? lat_q + 8'h01 : 8'h00;
      if (state_q == PPHP_IDLE)
      begin
        accRead_q <= isRead;
      end
    end
  end

  // Address phase on shared lines, data phase follows
  always_ff @(posedge clk)
  begin
    if (resetAll)
    begin
      muxAddr_q <= ADDR_RST;
      latchPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      latchPrev_q <= addrLatch;
      if (!demuxed && latchFall)
      begin
        muxAddr_q <= sharedIn[ADDR_W-1:0];
      end
    end
  end

  // Read data captured from core before ready
  always_ff @(posedge clk)
  begin
    if (resetAll)
    begin
      rdData_q <= DATA_RST;
    end
    else if (clkEn && state_q == PPHP_DONE && accRead_q)
    begin
      rdData_q <= coreRdata;
    end
  end

  // Supervision: latch input must keep toggling
  always_ff @(posedge clk)
  begin
    if (resetAll)
    begin
      supv_q <= '0;
      clockFail_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (latchFall)
      begin
        supv_q <= '0;
        clockFail_q <= 1'b0;
      end
      else if (supv_q == SW'(SUPV_LIMIT))
      begin
        clockFail_q <= 1'b1;
      end
      else
      begin
        supv_q <= supv_q + SW'(1);
      end
    end
  end

  assign coreReq = (state_q == PPHP_DONE);
  assign coreWrite = coreReq && !accRead_q;
  assign coreAddr = accAddr;
  assign coreWdata = sharedIn;
  assign sharedOut = rdData_q;
  assign sharedOe = isRead && accRead_q && (state_q == PPHP_HOLD);
  assign rdyOut = 1'b0;
  assign rdyOe = (state_q == PPHP_HOLD) && strobeOn;
  assign intOut = 1'b0;
  assign intOe = coreIrq && !resetAll;
  assign clockFail = clockFail_q;
endmodule

// File: pphp_core_model.sv
// Core-side register model answering reads.
// Assumes coreRdata is sampled in the request cycle.
`timescale 1ns/1ns
module pphp_core_model
(
  input wire logic [pphp_pkg::ADDR_W-1:0] coreAddr,
  output logic [pphp_pkg::DATA_W-1:0] coreRdata
);
  import pphp_pkg::*;
  assign coreRdata = {1'b0, coreAddr} ^ 8'h5A;
endmodule

// File: pphp_host_port_chk.sv
// Port checker for the parallel host port.
// Assumes one clock domain and rst_n as reset.
`timescale 1ns/1ns
module pphp_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_on_reset_n,
  input wire logic host_style_strap,
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic read_or_data_strobe_n,
  input wire logic writeOrDir,
  input wire logic coreIrq,
  input wire logic sharedOe,
  input wire logic rdyOe,
  input wire logic intOe,
  input wire logic coreReq,
  input wire logic coreWrite
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  drive_read_a: assert property (sharedOe |-> !read_or_data_strobe_n) else $error("oe");
  irq_pass_a: assert property (intOe == (coreIrq && power_on_reset_n)) else $error("irq");
  both_sel_a: assert property (coreReq |-> $past(!select_a_n && !select_b_n, 2))
    else $error("sel");
  dir_input_a: assert property (host_style_strap && coreReq |-> coreWrite == !$past(writeOrDir, 2))
    else $error("dir");
  sep_read_a: assert property (!host_style_strap && coreReq && !coreWrite
    |-> $past(!read_or_data_strobe_n, 2)) else $error("rd");
  sep_write_a: assert property (!host_style_strap && coreReq && coreWrite
    |-> $past(!writeOrDir, 2)) else $error("wr");
  read_ready_a: assert property (coreReq && !coreWrite ##1 !read_or_data_strobe_n
    |-> rdyOe && sharedOe) else $error("rdy rd");
  ready_after_a: assert property (rdyOe |-> $past(coreReq) || $past(rdyOe)) else $error("rdy");
endmodule
bind pphp_host_port pphp_chk chk_u (.*);

// File: testbench.sv
// Self-checking bench for the parallel host port.
// Assumes the core model answers reads combinationally.
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst_n = 0, clkEn = 1, power_on_reset_n = 1, host_style_strap = 0;
  logic bus_mux_strap = 0, select_a_n = 1, select_b_n = 1, addrLatch = 0, coreIrq = 0;
  logic read_or_data_strobe_n = 1, writeOrDir = 1;
  logic [6:0] dedicated_address_lines = 0, coreAddr;
  logic [7:0] sharedIn = 0, sharedOut, coreWdata, coreRdata;
  logic sharedOe, intOut, intOe, rdyOut, rdyOe, coreReq, coreWrite, clockFail;
  int mismatches = 0, total_checks = 0;
  always #20 clk = ~clk;
  pphp_host_port #(.SUPV_LIMIT(16)) dut_u (.*);
  pphp_core_model core_u (.*);
  task give_verdict;
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task acc(input bit ds, input bit mx, input bit wr, input logic [6:0] a, input logic [7:0] d);
    logic [6:0] ga;
    logic gw;
    logic [7:0] gd;
    int n;
    host_style_strap <= ds; bus_mux_strap <= !mx; select_a_n <= 0; select_b_n <= 0;
    sharedIn <= mx ? {1'b0, a} : d; dedicated_address_lines <= mx ? ~a : a; addrLatch <= mx;
    writeOrDir <= ds ? !wr : 1'b1;
    @(posedge clk) addrLatch <= 0;
    @(posedge clk) sharedIn <= d;
    read_or_data_strobe_n <= !ds && wr;
    if (!ds) writeOrDir <= !wr;
    for (n = 0; n < 9 && rdyOe !== 1; n++)
    begin
      @(posedge clk) #1;
      if (coreReq === 1) {ga, gw, gd} = {coreAddr, coreWrite, coreWdata};
    end
    if (n == 9) begin chk(0, "timeout"); give_verdict; end
    chk(ga === a, "addr");
    chk(gw === wr, "kind");
    chk(wr ? gd === d : sharedOut === ({1'b0, a} ^ 8'h5A) && sharedOe === 1, "data");
    chk(rdyOut === 0 && rdyOe === 1 && (wr ? sharedOe === 0 : 1'b1), "rdy");
    @(posedge clk) {read_or_data_strobe_n, writeOrDir, select_a_n, select_b_n} <= 4'hF;
    repeat (2) @(posedge clk);
  endtask
  task mode_sweep;
    for (int i = 0; i < 8; i++) acc(i[2], i[1], i[0], {i[2:0], 4'h5}, 8'hA0 ^ i[7:0]);
    acc(0, 1, 0, 7'h7F, 8'h00);
  endtask
  task unsel_case;
    select_a_n <= 0; host_style_strap <= 0; read_or_data_strobe_n <= 0;
    repeat (6) begin @(posedge clk) #1 chk(coreReq === 0 && sharedOe === 0, "unsel"); end
    @(posedge clk) {read_or_data_strobe_n, select_a_n} <= 2'h3;
  endtask
  task abort_case;
    host_style_strap <= 0; bus_mux_strap <= 1; select_a_n <= 0; select_b_n <= 0;
    read_or_data_strobe_n <= 0;
    @(posedge clk) clkEn <= 0;
    repeat (4) begin @(posedge clk) #1 chk(coreReq === 0 && rdyOe === 0, "freeze"); end
    @(posedge clk) {clkEn, read_or_data_strobe_n} <= 2'h3;
    repeat (5) begin @(posedge clk) #1 chk(coreReq === 0 && rdyOe === 0, "abort"); end
    {select_a_n, select_b_n} <= 2'h3;
    repeat (2) @(posedge clk);
  endtask
  task irq_case;
    coreIrq <= 1;
    @(posedge clk) #1 chk(intOe === 1 && intOut === 0, "irq");
    @(posedge clk) coreIrq <= 0;
    @(posedge clk) #1 chk(intOe === 0, "irq off");
  endtask
  task supv_case;
    repeat (20) @(posedge clk);
    #1 chk(clockFail === 1, "supv");
    @(posedge clk) power_on_reset_n <= 0;
    @(posedge clk) power_on_reset_n <= 1;
    #1 chk(clockFail === 0 && rdyOe === 0, "por");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    #1 chk(sharedOe === 0 && rdyOe === 0 && coreReq === 0, "reset");
    mode_sweep;
    unsel_case;
    abort_case;
    irq_case;
    supv_case;
    give_verdict;
  end
endmodule
